/* File: rtl/panel_sync_pulse_generator.sv */
// Sync pulse generator with Wishbone register slave
// Notes on behaviour
// - Pulse produced only while enable bit set
// - Period select: per line or per frame
// - Blanking bit clear suppresses pulses in blanking
// - Invert bit selects negative output polarity
// - Abnormal gate bit holds sync output low while abnormal
// - Pin source select picks sync/fault/vblank/latch
// - Code 2 picks gate enable or all-on
// - Delay is 11 bits over two registers
// - Line mode delay counts pixel clocks, min 1
// - Frame mode delay counts line syncs, min 1
// - Hold lasts code pixel clocks, min 1
// - Detect-off enable puts fault pin fixed
// - Detect-off level bit picks low or high
// - Source fault status only when enabled
`include "panel_sync_defines.svh"
module panel_sync_pulse_generator
   import panel_sync_pkg::*;
#(
   parameter int DLY_W  = 11,
   parameter int HOLD_W = 8
) (
   input  wire logic        CLOCK_I,        // Pixel clock
   input  wire logic        RST_I,          // Sync reset, high
   input  wire logic        CYC_I,          // Bus cycle
   input  wire logic        STB_I,          // Bus strobe
   input  wire logic        WE_I,           // Write enable
   input  wire logic [7:0]  ADR_I,          // Byte address
   input  wire logic [3:0]  SEL_I,          // Byte lanes
   input  wire logic [31:0] DAT_I,          // Write data
   output logic      [31:0] DAT_O,          // Read data
   output logic             ACK_O,          // Acknowledge
   input  wire logic        LINE_START_I,   // Line reference pulse
   input  wire logic        FRAME_START_I,  // Frame reference pulse
   input  wire logic        BLANK_I,        // Blanking interval
   input  wire logic        VBLANK_I,       // Vertical blanking
   input  wire logic        ABNORMAL_I,     // Abnormal state
   input  wire logic        FAULT_I,        // Internal fault signal
   input  wire logic        GATE_OE_I,      // Gate output enable
   input  wire logic        GATE_ALL_ON_I,  // Gate all-on
   input  wire logic        LATCH_LOAD_I,   // Latch load
   input  wire logic        SRC_FAULT_I,    // Source driver fault
   output logic             SYNC_PIN_O,     // Sync pin
   output logic             FAULT_PIN_O,    // Fault pin
   output logic             SRC_STATUS_O,   // Source fault status
   output logic             IRQ_O           // Interrupt, level
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   sync_ctrl_t   ctrl;
   logic [7:0]   dly_lo;
   logic [7:0]   hold_reg;
   logic [7:0]   dly_hi;
   logic [7:0]   fault_reg;
   logic [7:0]   status;
   logic [7:0]   mask;
   pulse_state_t state;
   logic [DLY_W-1:0]  dly_cnt;
   logic [HOLD_W-1:0] hold_cnt;
   logic [DLY_W-1:0]  dly_code;
   logic [DLY_W-1:0]  dly_eff;
   logic [HOLD_W-1:0] hold_eff;
   logic              req;
   logic              wr;
   logic              rd;
   logic [7:0]        idx;
   logic [7:0]        rd_byte;
   logic              reference;
   logic              tick;
   logic              active;
   logic              gated;
   logic              pulse_lvl;
   logic              next_pin;
   logic [7:0]        events;
   logic              status_rd;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign req = CYC_I & STB_I & ~ACK_O;
   assign wr  = req & WE_I & SEL_I[0];
   assign rd  = req & ~WE_I;
   assign idx = {2'h0, ADR_I[7:`ADR_LSB]};
   assign status_rd = rd & (idx == `IDX_STATUS);

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= req;
      end
   end

   always_comb begin
      case (idx)
         `IDX_CTRL:   rd_byte = ctrl;
         `IDX_DLY_LO: rd_byte = dly_lo;
         `IDX_HOLD:   rd_byte = hold_reg;
         `IDX_DLY_HI: rd_byte = dly_hi;
         `IDX_FAULT:  rd_byte = fault_reg;
         `IDX_STATUS: rd_byte = status;
         `IDX_MASK:   rd_byte = mask;
         default:     rd_byte = 8'h00;
      endcase
   end

   // Unmapped reads answer zero, unmapped writes are dropped
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         DAT_O <= 32'h0000_0000;
      end else if (rd) begin
         DAT_O <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ctrl      <= `RST_CTRL;
         dly_lo    <= `RST_DLY_LO;
         hold_reg  <= `RST_HOLD;
         dly_hi    <= `RST_DLY_HI;
         fault_reg <= `RST_FAULT;
         mask      <= 8'h00;
      end else if (wr) begin
         case (idx)
            `IDX_CTRL:   ctrl      <= DAT_I[7:0];
            `IDX_DLY_LO: dly_lo    <= DAT_I[7:0];
            `IDX_HOLD:   hold_reg  <= DAT_I[7:0];
            `IDX_DLY_HI: dly_hi    <= DAT_I[7:0] & `MSK_DLY_HI;
            `IDX_FAULT:  fault_reg <= DAT_I[7:0] & `MSK_FAULT;
            `IDX_MASK:   mask      <= DAT_I[7:0] & `MSK_IRQ;
            default:     ;
         endcase
      end
   end

   // ----------------------------------------
   // Counter setup
   // ----------------------------------------
   assign dly_code = {dly_hi[2:0], dly_lo};
   // Codes 0 and 1 both mean one unit
   assign dly_eff  = (dly_code == '0) ? DLY_W'(1) : dly_code;
   assign hold_eff = (hold_reg == '0) ? HOLD_W'(1) : hold_reg;
   assign reference = ctrl.per_frame ? FRAME_START_I : LINE_START_I;
   assign tick      = ctrl.per_frame ? LINE_START_I : 1'b1;

   // ----------------------------------------
   // Pulse sequencer
   // ----------------------------------------
   // A reference in any state restarts timing, so a stale
   // schedule never survives a short line or frame
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         state    <= ST_IDLE;
         dly_cnt  <= '0;
         hold_cnt <= '0;
      end else if (reference) begin
         if (!ctrl.per_frame && dly_eff == DLY_W'(1)) begin
            state    <= ST_HOLD;
            hold_cnt <= hold_eff;
         end else begin
            state   <= ST_DELAY;
            // Frame mode waits for whole line ticks; the reference itself is not one
            dly_cnt <= ctrl.per_frame ? dly_eff : dly_eff - DLY_W'(1);
         end
      end else begin
         case (state)
            ST_IDLE: begin
               state <= ST_IDLE;
            end
            ST_DELAY: begin
               if (tick) begin
                  if (dly_cnt == DLY_W'(1)) begin
                     state    <= ST_HOLD;
                     hold_cnt <= hold_eff;
                  end else begin
                     dly_cnt <= dly_cnt - DLY_W'(1);
                  end
               end
            end
            ST_HOLD: begin
               if (hold_cnt == HOLD_W'(1)) begin
                  state <= ST_IDLE;
               end else begin
                  hold_cnt <= hold_cnt - HOLD_W'(1);
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Output shaping
   // ----------------------------------------
   assign active = (state == ST_HOLD) & ctrl.enable
                 & (ctrl.in_blank | ~BLANK_I);
   assign gated  = ctrl.ab_gate & ABNORMAL_I;
   // Gating forces low after inversion, whatever the polarity
   assign pulse_lvl = gated ? 1'b0 : (active ^ ctrl.invert);

   always_comb begin
      case (ctrl.pin_sel)
         `SEL_SYNC:   next_pin = pulse_lvl;
         `SEL_FAULT:  next_pin = FAULT_I;
         `SEL_GATE:   next_pin = fault_reg[`B_GD_SEL] ?
                                 GATE_OE_I : GATE_ALL_ON_I;
         `SEL_VBLANK: next_pin = VBLANK_I;
         `SEL_LATCH:  next_pin = LATCH_LOAD_I;
         default:     next_pin = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         SYNC_PIN_O <= 1'b0;
      end else begin
         SYNC_PIN_O <= next_pin;
      end
   end

   // ----------------------------------------
   // Fault pin and source status
   // ----------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         FAULT_PIN_O <= 1'b0;
      end else if (fault_reg[`B_DET_OFF]) begin
         FAULT_PIN_O <= fault_reg[`B_DET_LVL];
      end else begin
         FAULT_PIN_O <= FAULT_I;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         SRC_STATUS_O <= 1'b0;
      end else begin
         SRC_STATUS_O <= SRC_FAULT_I & dly_hi[`B_SRC_DET];
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   always_comb begin
      events = 8'h00;
      events[`EV_PULSE] = active & ~gated
                        & (state == ST_HOLD) & (hold_cnt == hold_eff);
      events[`EV_GATED] = (state == ST_HOLD) & gated;
      events[`EV_SRC_FAULT] = SRC_FAULT_I & dly_hi[`B_SRC_DET];
   end

   // Read clears, but an event in the same cycle wins
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         status <= 8'h00;
      end else if (status_rd) begin
         status <= events;
      end else begin
         status <= status | events;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(status & mask);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   int unsigned       run_len;
   logic [HOLD_W-1:0] hold_seen;
   // Measured against the hold code loaded at entry, so a rewrite mid-pulse is legal
   always_ff @(posedge CLOCK_I) begin
      if (RST_I || state != ST_HOLD || reference) begin
         run_len   <= 0;
         hold_seen <= hold_eff;
      end else begin
         run_len <= run_len + 1;
      end
   end

   disabled_idle_a: assert property (
      (!ctrl.enable && !gated && ctrl.pin_sel == `SEL_SYNC)
      |=> SYNC_PIN_O == $past(ctrl.invert))
      else $error("Sync pin pulsed while disabled");

   line_delay_a: assert property (
      (LINE_START_I && !ctrl.per_frame && state == ST_IDLE
       && dly_eff == DLY_W'(9) && !FRAME_START_I)
      ##1 !LINE_START_I [*8]
      |=> state == ST_HOLD)
      else $error("Line delay count wrong");

   frame_tick_a: assert property (
      (ctrl.per_frame && state == ST_DELAY && !LINE_START_I
       && !FRAME_START_I)
      |=> $stable(dly_cnt))
      else $error("Frame delay moved without a line");

   hold_len_a: assert property (
      state == ST_HOLD |-> run_len < 32'(hold_seen))
      else $error("Hold ran too long");

   hold_end_a: assert property (
      (state == ST_HOLD && hold_cnt == HOLD_W'(1) && !reference)
      |=> state == ST_IDLE)
      else $error("Hold did not release");

   frame_ref_a: assert property (
      (ctrl.per_frame && LINE_START_I && !FRAME_START_I && state == ST_IDLE)
      |=> state == ST_IDLE)
      else $error("Line start began a frame pulse");

   inv_pol_a: assert property (
      (ctrl.enable && ctrl.invert && state == ST_HOLD && !gated
       && ctrl.pin_sel == `SEL_SYNC && (ctrl.in_blank || !BLANK_I))
      |=> !SYNC_PIN_O)
      else $error("Inverted pulse not low");

   blank_sup_a: assert property (
      (!ctrl.in_blank && BLANK_I && !gated
       && ctrl.pin_sel == `SEL_SYNC)
      |=> SYNC_PIN_O == $past(ctrl.invert))
      else $error("Pulse seen in blanking");

   ab_low_a: assert property (
      (gated && ctrl.pin_sel == `SEL_SYNC) |=> !SYNC_PIN_O)
      else $error("Gated sync pin not low");

   pin_mux_a: assert property (
      (ctrl.pin_sel == `SEL_VBLANK) |=> SYNC_PIN_O == $past(VBLANK_I))
      else $error("Vblank routing wrong");

   gate_mux_a: assert property (
      (ctrl.pin_sel == `SEL_GATE && !fault_reg[`B_GD_SEL])
      |=> SYNC_PIN_O == $past(GATE_ALL_ON_I))
      else $error("Gate all-on routing wrong");

   det_off_a: assert property (
      fault_reg[`B_DET_OFF] |=> FAULT_PIN_O == $past(fault_reg[`B_DET_LVL]))
      else $error("Detect-off level wrong");

   fault_norm_a: assert property (
      !fault_reg[`B_DET_OFF] |=> FAULT_PIN_O == $past(FAULT_I))
      else $error("Fault pin not following fault");

   src_stat_a: assert property (
      !dly_hi[`B_SRC_DET] |=> !SRC_STATUS_O)
      else $error("Source status while disabled");

   ack_once_a: assert property (
      ACK_O |=> !ACK_O)
      else $error("Ack held two cycles");

   line_pulse_c: cover property (
      !ctrl.per_frame && ctrl.enable && state == ST_HOLD);
   frame_pulse_c: cover property (
      ctrl.per_frame && ctrl.enable && state == ST_HOLD);
   irq_c: cover property (IRQ_O ##1 status_rd);
   invert_pulse_c: cover property (
      ctrl.invert && ctrl.enable && state == ST_HOLD);
   gated_hold_c: cover property (gated && state == ST_HOLD);

endmodule : panel_sync_pulse_generator

/* File: rtl/panel_sync_defines.svh */
// Register map, reset values and field positions of the sync pulse generator
`ifndef PANEL_SYNC_DEFINES_SVH
`define PANEL_SYNC_DEFINES_SVH
// ----------------------------------------
// Register indices, byte address is 4x
// ----------------------------------------
`define IDX_CTRL      8'h1c
`define IDX_DLY_LO    8'h1d
`define IDX_HOLD      8'h1e
`define IDX_DLY_HI    8'h1f
`define IDX_FAULT     8'h15
`define IDX_STATUS    8'h30
`define IDX_MASK      8'h31
`define ADR_LSB       2
// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define RST_CTRL      8'h24
`define RST_DLY_LO    8'h09
`define RST_HOLD      8'h18
`define RST_DLY_HI    8'h00
`define RST_FAULT     8'h04
`define MSK_DLY_HI    8'h17
`define MSK_FAULT     8'h0d
`define MSK_IRQ       8'h07
// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_SRC_DET     4
`define B_DET_OFF     3
`define B_DET_LVL     2
`define B_GD_SEL      0
`define EV_PULSE      0
`define EV_GATED      1
`define EV_SRC_FAULT  2
// ----------------------------------------
// Pin source codes
// ----------------------------------------
`define SEL_SYNC      3'h0
`define SEL_FAULT     3'h1
`define SEL_GATE      3'h2
`define SEL_VBLANK    3'h3
`define SEL_LATCH     3'h4
`endif

/* File: rtl/panel_sync_pkg.sv */
// Types shared by the sync pulse generator
package panel_sync_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_HOLD  = 3'b100
   } pulse_state_t;
   typedef struct packed {
      logic       enable;
      logic       per_frame;
      logic       in_blank;
      logic       invert;
      logic       ab_gate;
      logic [2:0] pin_sel;
   } sync_ctrl_t;
endpackage : panel_sync_pkg

/* File: bench/sync_partner.sv */
// Line/frame timing source and sync pin sampler standing on the far side
// ----------------------------------------
// Timing source and pin monitor
// ----------------------------------------
module sync_partner #(
   parameter int PERIOD = 100
) (
   input  wire logic clk_i,    // Pixel clock
   input  wire logic rst_i,    // Sync reset
   input  wire logic pin_i,    // Sync pin
   input  wire logic inv_i,    // Expected inactive level
   input  int        len_i,    // Line length in clocks
   output logic      line_o,   // Line reference pulse
   output logic      frame_o,  // Frame reference pulse
   output int        n_rise_o, // Count of pulse starts
   output int        dly_o,    // Start delay from line reference
   output int        fdly_o,   // Start delay from frame reference
   output int        wid_o     // Last active width
);
   timeunit 1ns;
   timeprecision 1ns;
   int   cnt = 0;
   int   ln  = 0;
   time  t_ref, t_fref, t_up;
   logic act;
   assign act = pin_i ^ inv_i;
   initial n_rise_o = 0;
   // Line kept longer than delay plus hold by the bench choice of len_i
   always @(posedge clk_i) begin
      if (line_o) t_ref = $time;
      if (frame_o) t_fref = $time;
      if (rst_i) begin
         cnt <= 0;
         ln <= 0;
         line_o <= 1'b0;
         frame_o <= 1'b0;
      end else begin
         line_o <= (cnt >= len_i - 1);
         frame_o <= (cnt >= len_i - 1) && (ln == 3);
         cnt <= (cnt >= len_i - 1) ? 0 : cnt + 1;
         if (cnt >= len_i - 1) ln <= (ln == 3) ? 0 : ln + 1;
      end
   end
   always @(posedge act) begin
      t_up = $time;
      n_rise_o++;
      dly_o = (t_up - t_ref) / PERIOD;
      fdly_o = (t_up - t_fref) / PERIOD;
   end
   always @(negedge act) wid_o = ($time - t_up) / PERIOD;
endmodule : sync_partner

/* File: bench/tb_top.sv */
// Self-checking bench of the sync pulse generator
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, cyc, stb, we, ack, inv;
   logic        line_s, frame_s, sync_pin, fault_pin, src_st, irq;
   logic [7:0]  adr, src;
   logic [3:0]  sel;
   logic [31:0] dat, dat_o, rd;
   int          len, n_rise, dly, fdly, wid, n0;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          idx [6] = '{0, 0, 1, 3, 4, 5};
   panel_sync_pulse_generator DUT (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
      .LINE_START_I(line_s), .FRAME_START_I(frame_s), .BLANK_I(src[6]), .VBLANK_I(src[3]),
      .ABNORMAL_I(src[7]), .FAULT_I(src[0]), .GATE_OE_I(src[1]), .GATE_ALL_ON_I(src[2]),
      .LATCH_LOAD_I(src[4]), .SRC_FAULT_I(src[5]), .SYNC_PIN_O(sync_pin),
      .FAULT_PIN_O(fault_pin), .SRC_STATUS_O(src_st), .IRQ_O(irq));
   sync_partner u_far (.clk_i(clk), .rst_i(rst), .pin_i(sync_pin), .inv_i(inv), .len_i(len),
      .line_o(line_s), .frame_o(frame_s), .n_rise_o(n_rise), .dly_o(dly), .fdly_o(fdly),
      .wid_o(wid));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Holds the request until ack is sampled high, then releases it
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h000000, d};
      sel <= 4'h1;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h000000, e});
   endtask : rdc
   task automatic drive(input logic [7:0] v);
      @(posedge clk);
      src <= v;
      repeat (2) @(posedge clk);
      #1;
   endtask : drive
   task automatic lines(input int n);
      repeat (n * len) @(posedge clk);
      #1;
   endtask : lines
   task automatic pulse(input logic [10:0] d, input logic [7:0] h, input int ed, input int eh);
      wr(8'h74, d[7:0]);
      wr(8'h7c, {5'h00, d[10:8]});
      wr(8'h78, h);
      lines(3);
      chk(dly, ed);
      chk(wid, eh);
   endtask : pulse
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_mismatch++;
         final_report();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst, cyc, stb, we, inv} = 5'b10000;
      {adr, src, sel, dat} = '0;
      len = 64;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h70, 8'h24);
      rdc(8'h74, 8'h09);
      rdc(8'h78, 8'h18);
      rdc(8'h7c, 8'h00);
      rdc(8'h54, 8'h04);
      wr(8'h00, 8'h5a);
      rdc(8'h00, 8'h00);
      wr(8'h7c, 8'hff);
      rdc(8'h7c, 8'h17);
      wr(8'h54, 8'h05);
      for (int c = 1; c < 6; c++) begin
         wr(8'h70, 8'(c));
         for (int v = 0; v < 2; v++) begin
            drive(v ? (8'h01 << idx[c]) : (~(8'h01 << idx[c]) & 8'h1f));
            chk(sync_pin, (c < 5) ? v : 0);
         end
      end
      wr(8'h54, 8'h04);
      wr(8'h70, 8'h02);
      drive(8'h04);
      chk(sync_pin, 1'b1);
      drive(8'h1b);
      chk(sync_pin, 1'b0);
      drive(8'h01);
      chk(fault_pin, 1'b1);
      wr(8'h54, 8'h08);
      drive(8'h01);
      chk(fault_pin, 1'b0);
      wr(8'h54, 8'h0c);
      drive(8'h00);
      chk(fault_pin, 1'b1);
      wr(8'h7c, 8'h00);
      drive(8'h20);
      chk(src_st, 1'b0);
      wr(8'h7c, 8'h10);
      drive(8'h20);
      chk(src_st, 1'b1);
      wr(8'hc4, 8'h04);
      drive(8'h20);
      chk(irq, 1'b1);
      wr(8'hc4, 8'h00);
      drive(8'h20);
      chk(irq, 1'b0);
      wr(8'hc4, 8'h04);
      drive(8'h00);
      rdc(8'hc0, 8'h04);
      drive(8'h00);
      chk(irq, 1'b0);
      rdc(8'hc0, 8'h00);
      rdc(8'hc4, 8'h04);
      wr(8'h70, 8'ha0);
      pulse(11'h000, 8'h00, 1, 1);
      pulse(11'h001, 8'h01, 1, 1);
      pulse(11'h009, 8'h18, 9, 24);
      n0 = n_rise;
      lines(4);
      chk(n_rise - n0, 4);
      len = 600;
      pulse(11'h105, 8'hff, 261, 255);
      rdc(8'hc0, 8'h01);
      inv <= 1'b1;
      wr(8'h70, 8'hb0);
      lines(3);
      chk(wid, 255);
      len = 64;
      wr(8'h78, 8'h05);
      wr(8'h74, 8'h09);
      wr(8'h7c, 8'h00);
      wr(8'h70, 8'h30);
      lines(1);
      n0 = n_rise;
      lines(2);
      chk(n_rise, n0);
      chk(sync_pin, 1'b1);
      inv <= 1'b0;
      wr(8'h70, 8'h80);
      drive(8'h40);
      n0 = n_rise;
      lines(2);
      chk(n_rise, n0);
      wr(8'h70, 8'ha0);
      lines(2);
      chk(n_rise > n0, 1'b1);
      wr(8'h70, 8'ha8);
      rdc(8'hc0, 8'h01);
      drive(8'h80);
      n0 = n_rise;
      lines(2);
      chk(n_rise, n0);
      chk(sync_pin, 1'b0);
      wr(8'h70, 8'ha0);
      lines(2);
      chk(n_rise > n0, 1'b1);
      rdc(8'hc0, 8'h03);
      drive(8'h00);
      wr(8'h74, 8'h02);
      wr(8'h70, 8'he0);
      lines(4);
      n0 = n_rise;
      lines(8);
      chk(n_rise - n0, 2);
      chk(fdly >= 2 * len && fdly <= 2 * len + 2, 1'b1);
      final_report();
   end
endmodule : tb_top
